/* File: gpd_axi_master.sv */
// axi4-lite master model standing in for the processor side of the gpio block
`timescale 1ns/1ps
module gpd_axi_master (
   input wire logic clk_sys,
   output gpd_pkg::gpd_addr_t awaddr,
   output logic awvalid,
   input wire logic awready,
   output gpd_pkg::gpd_word_t wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output gpd_pkg::gpd_addr_t araddr,
   output logic arvalid,
   input wire logic arready,
   input wire gpd_pkg::gpd_word_t rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   import gpd_pkg::*;
   // idle until the bench calls a task, which it does only after reset is released
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // address and data held until both readies are seen at an edge
   task automatic wr(input gpd_addr_t a, input gpd_word_t d, input logic [3:0] s, output logic [1:0] resp);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge clk_sys); while (!(awready === 1'b1 && wready === 1'b1) && ++n < 50);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      // released address and data show the inverse, never a stale copy; wstrb keeps its value
      awaddr <= ~a;
      wdata <= ~d;
      bready <= 1'b1;
      do @(posedge clk_sys); while (bvalid !== 1'b1 && ++n < 100);
      // a timed-out transfer hands back unknowns so the caller's compare fails
      resp = (bvalid === 1'b1) ? bresp : 2'bxx;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input gpd_addr_t a, output gpd_word_t d, output logic [1:0] resp);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1 && ++n < 50);
      arvalid <= 1'b0;
      araddr <= ~a;
      rready <= 1'b1;
      do @(posedge clk_sys); while (rvalid !== 1'b1 && ++n < 100);
      d = (rvalid === 1'b1) ? rdata : 'x;
      resp = (rvalid === 1'b1) ? rresp : 2'bxx;
      rready <= 1'b0;
   endtask : rd
endmodule : gpd_axi_master

/* File: gpd_chan.sv */
// one gpio channel: output data, direction, input synchroniser and change detect
`timescale 1ns/1ps
`include "gpd_defs.svh"
module gpd_chan #(
   parameter int WIDTH = 32,
   parameter logic [31:0] DOUT_RST = 32'h00000000,
   parameter logic [31:0] TRI_RST = 32'hFFFFFFFF
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_data,
   input wire logic wr_dir,
   input wire gpd_pkg::gpd_word_t wdata,
   input wire logic [3:0] wstrb,
   input wire gpd_pkg::gpd_word_t gpio_i,
   output gpd_pkg::gpd_pins_t pins,
   output gpd_pkg::gpd_word_t rd_data,
   output gpd_pkg::gpd_word_t rd_dir,
   output logic chg
);
   import gpd_pkg::*;

   localparam gpd_word_t MASK = gpd_mask(WIDTH);
   gpd_chan_st_t st_reg;
   gpd_chan_st_t st_next;

   always_comb
   begin
      st_next = st_reg;
      // pins pass two flops before anything looks at them
      st_next.sync1 = gpio_i & MASK;
      st_next.sync2 = st_reg.sync1;
      st_next.prev = st_reg.sync2;
      if (st_reg.fill != `GPD_FILL_DONE)
         st_next.fill = st_reg.fill + 2'h1;
      if (wr_data)
         st_next.dout = gpd_merge(st_reg.dout, wdata, wstrb) & MASK;
      // direction register holds 1 for input, so the enable is its inverse
      if (wr_dir)
         st_next.oe = ~gpd_merge(~st_reg.oe, wdata, wstrb) & MASK;
      if (!rst_n)
      begin
         st_next = '0;
         st_next.dout = DOUT_RST & MASK;
         st_next.oe = ~TRI_RST & MASK;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      st_reg <= st_next;
   end

   assign pins.o = st_reg.dout;
   assign pins.oe = st_reg.oe;
   // inputs read back the pin, outputs read back what is driven
   assign rd_data = (st_reg.sync2 & ~st_reg.oe) | (st_reg.dout & st_reg.oe);
   assign rd_dir = ~st_reg.oe & MASK;
   // priming stops a pin already high at reset from raising a change
   assign chg = (st_reg.fill == `GPD_FILL_DONE) && |((st_reg.sync2 ^ st_reg.prev) & ~st_reg.oe);

   chk_oe_width: assert property (@(posedge clk_sys) disable iff (!rst_n) (pins.oe & ~MASK) == '0)
      else $error("enable driven above channel width");
   chk_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_dir && wstrb == 4'hF |=> pins.oe == (~$past(wdata) & MASK))
      else $error("direction write not applied");
   chk_input_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) && $past(rst_n, 2) |-> (rd_data & ~pins.oe) == ($past(gpio_i, 2) & MASK & ~pins.oe))
      else $error("input readback not two cycles behind pin");
   // tied to the pin itself, so a broken synchroniser or compare shows up here
   chk_change_seen: assert property (@(posedge clk_sys) disable iff (!rst_n)
      chg |-> ((($past(gpio_i, 2) ^ $past(gpio_i, 3)) & MASK & ~pins.oe) != '0))
      else $error("change flagged with no input change");
endmodule : gpd_chan

/* File: gpd_defs.svh */
// register offsets, response codes and layout constants for the gpio block
`ifndef GPD_DEFS_SVH
`define GPD_DEFS_SVH
`define GPD_AW 9
`define GPD_DW 32
`define GPD_OFF_DATA1 9'h000
`define GPD_OFF_DIR1 9'h004
`define GPD_CH_STRIDE 9'h008
`define GPD_OFF_IEN 9'h010
`define GPD_OFF_ISTS 9'h014
`define GPD_RESP_OKAY 2'h0
`define GPD_RESP_SLVERR 2'h2
`define GPD_IEN_GLOBAL 2
`define GPD_FILL_DONE 2'h3
`define GPD_ONE_WORD 32'hFFFFFFFF
`endif

/* File: gpd_pkg.sv */
// types and helper functions shared by the gpio block
package gpd_pkg;
   typedef logic [31:0] gpd_word_t;
   typedef logic [8:0] gpd_addr_t;

   // pin bundle handed to the pad buffers outside
   typedef struct packed {
      gpd_word_t o;
      gpd_word_t oe;
   } gpd_pins_t;

   typedef struct packed {
      gpd_word_t dout;
      gpd_word_t oe;
      gpd_word_t sync1;
      gpd_word_t sync2;
      gpd_word_t prev;
      logic [1:0] fill;
   } gpd_chan_st_t;

   typedef struct packed {
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      gpd_word_t rdata;
      logic [2:0] ien;
      logic [1:0] ists;
      logic irq;
   } gpd_top_st_t;

   function automatic gpd_word_t gpd_merge(input gpd_word_t old_v, input gpd_word_t new_v,
                                           input logic [3:0] strb);
      gpd_word_t r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            r[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return r;
   endfunction : gpd_merge

   function automatic gpd_word_t gpd_mask(input int w);
      gpd_word_t r;
      r = '0;
      for (int i = 0; i < 32; i++)
      begin
         if (i < w)
            r[i] = 1'b1;
      end
      return r;
   endfunction : gpd_mask
endpackage : gpd_pkg

/* File: gpd_top.sv */
// gpio block with axi4-lite slave, one or two channels and optional interrupt
`timescale 1ns/1ps
`include "gpd_defs.svh"
module gpd_top #(
   parameter int NUM_CH = 2,
   parameter int CH1_WIDTH = 32,
   parameter int CH2_WIDTH = 32,
   parameter logic [31:0] CH1_DOUT_RST = 32'h00000000,
   parameter logic [31:0] CH1_TRI_RST = 32'hFFFFFFFF,
   parameter logic [31:0] CH2_DOUT_RST = 32'h00000000,
   parameter logic [31:0] CH2_TRI_RST = 32'hFFFFFFFF,
   parameter logic [2:0] IEN_RST = 3'h0,
   parameter bit interrupt_logic_included = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire gpd_pkg::gpd_addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire gpd_pkg::gpd_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire gpd_pkg::gpd_addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output gpd_pkg::gpd_word_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire gpd_pkg::gpd_word_t [1:0] gpio_i,
   output gpd_pkg::gpd_pins_t [1:0] gpio_pins,
   output logic irq
);
   import gpd_pkg::*;

   gpd_top_st_t st_reg;
   gpd_top_st_t st_next;
   logic wr_hs;
   logic rd_hs;
   logic [1:0] wr_data_sel;
   logic [1:0] wr_dir_sel;
   logic [1:0] chg;
   gpd_word_t [1:0] ch_rd;
   gpd_word_t [1:0] ch_dir;

   // offset of a channel's data register; direction sits one word above
   function automatic gpd_addr_t ch_off(input int ch);
      return `GPD_OFF_DATA1 + gpd_addr_t'(ch) * `GPD_CH_STRIDE;
   endfunction : ch_off

   function automatic logic addr_ok(input gpd_addr_t a);
      logic ok;
      ok = (a == `GPD_OFF_IEN) || (a == `GPD_OFF_ISTS);
      for (int c = 0; c < 2; c++)
      begin
         if (c < NUM_CH && (a == ch_off(c) || a == ch_off(c) + `GPD_OFF_DIR1))
            ok = 1'b1;
      end
      return ok;
   endfunction : addr_ok

   // address and data are taken together; one write outstanding at a time
   assign wr_hs = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
   assign rd_hs = s_axi_arvalid && !st_reg.rvalid;
   assign s_axi_awready = wr_hs;
   assign s_axi_wready = wr_hs;
   assign s_axi_arready = !st_reg.rvalid;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gen_ch
         if (g < NUM_CH)
         begin : gen_on
            assign wr_data_sel[g] = wr_hs && s_axi_awaddr == ch_off(g);
            assign wr_dir_sel[g] = wr_hs && s_axi_awaddr == ch_off(g) + `GPD_OFF_DIR1;
            gpd_chan #(
               .WIDTH(g == 0 ? CH1_WIDTH : CH2_WIDTH),
               .DOUT_RST(g == 0 ? CH1_DOUT_RST : CH2_DOUT_RST),
               .TRI_RST(g == 0 ? CH1_TRI_RST : CH2_TRI_RST)
            ) u_chan (
               .clk_sys(clk_sys),
               .rst_n(rst_n),
               .wr_data(wr_data_sel[g]),
               .wr_dir(wr_dir_sel[g]),
               .wdata(s_axi_wdata),
               .wstrb(s_axi_wstrb),
               .gpio_i(gpio_i[g]),
               .pins(gpio_pins[g]),
               .rd_data(ch_rd[g]),
               .rd_dir(ch_dir[g]),
               .chg(chg[g])
            );
         end
         else
         begin : gen_off
            assign wr_data_sel[g] = 1'b0;
            assign wr_dir_sel[g] = 1'b0;
            assign gpio_pins[g] = '0;
            assign ch_rd[g] = '0;
            assign ch_dir[g] = '0;
            assign chg[g] = 1'b0;
         end
      end
   endgenerate

   always_comb
   begin
      st_next = st_reg;
      if (st_reg.bvalid && s_axi_bready)
         st_next.bvalid = 1'b0;
      if (st_reg.rvalid && s_axi_rready)
         st_next.rvalid = 1'b0;
      if (wr_hs)
      begin
         st_next.bvalid = 1'b1;
         st_next.bresp = addr_ok(s_axi_awaddr) ? `GPD_RESP_OKAY : `GPD_RESP_SLVERR;
         if (s_axi_awaddr == `GPD_OFF_IEN && s_axi_wstrb[0])
            st_next.ien = s_axi_wdata[2:0];
         // write one to clear
         if (s_axi_awaddr == `GPD_OFF_ISTS && s_axi_wstrb[0])
            st_next.ists = st_reg.ists & ~s_axi_wdata[1:0];
      end
      // an event in the clearing cycle survives: set wins over clear
      st_next.ists = st_next.ists | chg;
      st_next.irq = st_reg.ien[`GPD_IEN_GLOBAL] && |(st_reg.ists & st_reg.ien[1:0]);
      if (rd_hs)
      begin
         st_next.rvalid = 1'b1;
         st_next.rresp = addr_ok(s_axi_araddr) ? `GPD_RESP_OKAY : `GPD_RESP_SLVERR;
         st_next.rdata = '0;
         for (int c = 0; c < 2; c++)
         begin
            if (s_axi_araddr == ch_off(c))
               st_next.rdata = ch_rd[c];
            if (s_axi_araddr == ch_off(c) + `GPD_OFF_DIR1)
               st_next.rdata = ch_dir[c];
         end
         if (s_axi_araddr == `GPD_OFF_IEN)
            st_next.rdata = {29'h0, st_reg.ien};
         if (s_axi_araddr == `GPD_OFF_ISTS)
            st_next.rdata = {30'h0, st_reg.ists};
      end
      if (!interrupt_logic_included)
      begin
         st_next.ien = '0;
         st_next.ists = '0;
         st_next.irq = 1'b0;
      end
      if (!rst_n)
      begin
         st_next = '0;
         st_next.ien = interrupt_logic_included ? IEN_RST : 3'h0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      st_reg <= st_next;
   end

   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rresp = st_reg.rresp;
   assign s_axi_rdata = st_reg.rdata;
   assign irq = st_reg.irq;

   chk_bresp_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_hs |=> s_axi_bvalid && s_axi_bresp == ($past(addr_ok(s_axi_awaddr)) ? 2'h0 : 2'h2))
      else $error("write response code wrong");
   chk_bvalid_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   chk_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 (!s_axi_arready))
      else $error("read not answered next cycle");
   chk_irq_absent: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !interrupt_logic_included |-> !irq && st_reg.ists == 2'h0)
      else $error("interrupt logic active while excluded");
   chk_event_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      interrupt_logic_included && chg[1] ##1 !wr_hs |-> st_reg.ists[1] [*2])
      else $error("channel event not held");
   chk_reset_idle: assert property (@(posedge clk_sys)
      !rst_n |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("outputs not idle after reset");
endmodule : gpd_top

/* File: tb_top.sv */
// self-checking bench for the gpio block with a two channel, interrupt build
`timescale 1ns/1ps
`include "gpd_defs.svh"
module tb_top;
   import gpd_pkg::*;
   logic clk_sys;
   logic rst_n;
   gpd_addr_t awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
   gpd_word_t wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   gpd_word_t [1:0] gpio_i;
   gpd_pins_t [1:0] gpio_pins;
   gpd_word_t rv;
   int error_cnt = 0;
   int tests_run = 0;
   // narrow channel 1 with mixed reset values exposes width masking
   gpd_top #(.NUM_CH(2), .CH1_WIDTH(8), .CH1_DOUT_RST(32'h000000A5), .CH1_TRI_RST(32'h0000000F)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_i(gpio_i),
      .gpio_pins(gpio_pins), .irq(irq));
   gpd_axi_master mst (
      .clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk_word(input string nm, input gpd_word_t e, input gpd_word_t g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word
   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_resp
   task automatic wok(input gpd_addr_t a, input gpd_word_t d, input logic [3:0] s);
      mst.wr(a, d, s, resp);
      chk_resp("bresp", `GPD_RESP_OKAY, resp);
   endtask : wok
   task automatic t_reset();
      chk_word("ch1 o", 32'h000000A5, gpio_pins[0].o);
      chk_word("ch1 oe", 32'h000000F0, gpio_pins[0].oe);
      chk_word("ch2 oe", 32'h00000000, gpio_pins[1].oe);
      mst.rd(`GPD_OFF_DIR1, rv, resp);
      chk_word("dir1", 32'h0000000F, rv);
      chk_resp("rresp", `GPD_RESP_OKAY, resp);
      $display("test reset done");
   endtask : t_reset
   task automatic t_out();
      wok(`GPD_OFF_DIR1, 32'h00000000, 4'hF);
      wok(`GPD_OFF_DATA1, 32'h123456C3, 4'hF);
      chk_word("ch1 o", 32'h000000C3, gpio_pins[0].o);
      chk_word("ch1 oe", 32'h000000FF, gpio_pins[0].oe);
      wok(`GPD_OFF_DATA1 + `GPD_CH_STRIDE + 9'h004, 32'h00000000, 4'hF);
      wok(`GPD_OFF_DATA1 + `GPD_CH_STRIDE, 32'hAABBCCDD, 4'h2);
      chk_word("ch2 o", 32'h0000CC00, gpio_pins[1].o);
      chk_word("ch2 oe", 32'hFFFFFFFF, gpio_pins[1].oe);
      mst.rd(`GPD_OFF_DATA1, rv, resp);
      chk_word("data1", 32'h000000C3, rv);
      chk_resp("rresp data1", `GPD_RESP_OKAY, resp);
      $display("test output done");
   endtask : t_out
   task automatic t_in_err();
      wok(`GPD_OFF_DATA1 + `GPD_CH_STRIDE + 9'h004, 32'hFFFFFFFF, 4'hF);
      gpio_i[1] <= 32'h5A5A0001;
      repeat (4) @(posedge clk_sys);
      mst.rd(`GPD_OFF_DATA1 + `GPD_CH_STRIDE, rv, resp);
      chk_word("data2 in", 32'h5A5A0001, rv);
      chk_word("ch2 oe", 32'h00000000, gpio_pins[1].oe);
      mst.wr(9'h100, 32'h00000001, 4'hF, resp);
      chk_resp("bresp bad", `GPD_RESP_SLVERR, resp);
      mst.rd(9'h100, rv, resp);
      chk_resp("rresp bad", `GPD_RESP_SLVERR, resp);
      chk_word("rdata bad", 32'h00000000, rv);
      $display("test input done");
   endtask : t_in_err
   task automatic t_irq();
      int n;
      wok(`GPD_OFF_IEN, 32'h00000007, 4'h1);
      wok(`GPD_OFF_ISTS, 32'h00000003, 4'h1);
      // ch1 is all outputs, so pin activity there must not count as an event
      gpio_i[0] <= 32'h000000FF;
      repeat (8) @(posedge clk_sys);
      chk_word("irq quiet", 32'h0, {31'h0, irq});
      gpio_i[1] <= 32'h5A5A0003;
      n = 0;
      do @(posedge clk_sys); while (irq !== 1'b1 && ++n < 8);
      chk_word("irq", 32'h1, {31'h0, irq});
      mst.rd(`GPD_OFF_ISTS, rv, resp);
      chk_word("ists", 32'h00000002, rv);
      wok(`GPD_OFF_ISTS, 32'h00000002, 4'h1);
      repeat (3) @(posedge clk_sys);
      chk_word("irq clr", 32'h0, {31'h0, irq});
      $display("test interrupt done");
   endtask : t_irq
   task automatic t_rerst();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk_word("ch1 o rst", 32'h000000A5, gpio_pins[0].o);
      chk_word("ch1 oe rst", 32'h000000F0, gpio_pins[0].oe);
      chk_word("irq rst", 32'h0, {31'h0, irq});
      @(posedge clk_sys);
      rst_n <= 1'b1;
      // first request on the edge after release; pins held high through reset must not raise events
      @(posedge clk_sys);
      mst.rd(`GPD_OFF_DIR1, rv, resp);
      chk_word("dir1 rst", 32'h0000000F, rv);
      mst.rd(`GPD_OFF_IEN, rv, resp);
      chk_word("ien rst", 32'h00000000, rv);
      repeat (4) @(posedge clk_sys);
      mst.rd(`GPD_OFF_ISTS, rv, resp);
      chk_word("ists primed", 32'h00000000, rv);
      $display("test second reset done");
   endtask : t_rerst
   initial
   begin
      rst_n = 1'b0;
      gpio_i = '0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_out();
      t_in_err();
      t_irq();
      t_rerst();
      tally_and_finish();
   end
   // every task waits a bounded count, so this span is far beyond a clean run
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb_top
